// *** logic/ctu_trap_unit.sv ***
// trap handling unit: per-priority enables and status, trap entry and return, descriptor transfers
`timescale 1ns/1ps
`default_nettype none
`include "ctu_regs.svh"

// Function
// - descriptor is four words: mask, status, workspace, iptr
// - null workspace pointer means no handler installed
// - saved iptr is next instruction, status bit set
// - trap only at interruptible point when enabled
// - disabled cause ignored, enabled cause recorded in status
// - save live context, load handler context
// - live mask ANDed with handler mask on entry
// - trap return restores saved context, clears flag
// - group from stack top, buffer from second
// - handler ops use third register priority; saved ops current
// - load guard enabled: skip load, set flag
// - store guard enabled: skip store, set flag
// - cause enables in low half, one per priority
// - mask set ORs stack top into enables
// - mask clear ANDs inverted stack top into enables
// - mask ops return previous enables in stack top
// - undefined opcode raises bad opcode condition
// - group codes: break 0, errors 1, system 2, scheduler 3
// - cause bits 0 to 13; bit 15 software forced

module ctu_trap_unit (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic op_valid_i,
    input wire ctu_pkg::ctu_op_e op_i,
    input wire ctu_pkg::ctu_stack_s stack_i,
    input wire logic pri_i,
    input wire ctu_pkg::ctu_ctx_s ctx_i,
    input wire logic interruptible_i,
    input wire logic [13:0] cond_i,
    input wire logic sw_forced_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output ctu_pkg::ctu_mem_s mem_o,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] areg_o,
    output logic ctx_load_o,
    output ctu_pkg::ctu_ctx_s ctx_o,
    output logic [3:0] trap_cause_o,
    output logic [63:0] enables_o,
    output logic [31:0] status_o
);
    import ctu_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ****************************************
    // state
    // ****************************************
    ctu_state_e state, next_state;
    ctu_job_e job;
    logic [1:0] cnt, next_cnt;
    logic [31:0] buf_q [4];
    logic [31:0] src_base, dst_base;
    logic job_pri;
    logic [3:0] job_cause;
    logic [31:0] sv_iptr, sv_wptr;
    logic [31:0] enables [2];
    logic [15:0] status [2];
    logic [3:0] cause_taken [2];

    // ****************************************
    // decode
    // ****************************************
    logic [13:0] pending;
    logic pend_any;
    logic [3:0] pend_idx;
    logic idle, take_trap, op_go, last_ack;
    logic guard_load, guard_store;
    logic [15:0] events;
    logic [31:0] wdata;
    logic load_op, store_op;

    function automatic logic [1:0] group_of(input logic [3:0] cause);
        if (cause == `CTU_BIT_BREAK) begin
            return `CTU_GRP_BREAK;
        end else if (cause < `CTU_BIT_BAD_OP) begin
            return `CTU_GRP_ERRORS;
        end else if (cause <= `CTU_BIT_STORE_GUARD) begin
            return `CTU_GRP_SYSTEM;
        end
        return `CTU_GRP_SCHED;
    endfunction

    // one 16-byte slot per priority and group
    function automatic logic [31:0] slot(input logic [31:0] base, input logic p, input logic [1:0] g);
        return base + {26'h0, p, g, 3'h0} + {26'h0, p, g, 3'h0};
    endfunction

    // pending causes are served one at a time, lowest bit first
    assign pending = status[pri_i][13:0] & enables[pri_i][13:0];

    ctu_lowest_bit u_pick (
        .vec_i(pending),
        .any_o(pend_any),
        .idx_o(pend_idx)
    );

    assign idle = (state == CTU_ST_IDLE);
    // a trap beats an op in the same cycle; the op must be presented again
    assign take_trap = idle && interruptible_i && pend_any;
    assign op_go = idle && op_valid_i && !take_trap;
    assign last_ack = mem_ack_i && (cnt == `CTU_LAST_WORD);
    assign guard_load = enables[pri_i][`CTU_BIT_LOAD_GUARD];
    assign guard_store = enables[pri_i][`CTU_BIT_STORE_GUARD];
    assign load_op = op_go && (op_i == CTU_OP_LD_HANDLER || op_i == CTU_OP_LD_SAVED);
    assign store_op = op_go && (op_i == CTU_OP_ST_HANDLER || op_i == CTU_OP_ST_SAVED);

    // events for the current priority, gated by its enables except the software forced bit
    always_comb begin
        events = {2'h0, cond_i};
        if (op_go && op_i == CTU_OP_BAD_OP) begin
            events[`CTU_BIT_BAD_OP] = 1'b1;
        end
        if (op_go && (op_i == CTU_OP_LD_HANDLER || op_i == CTU_OP_LD_SAVED)) begin
            events[`CTU_BIT_LOAD_GUARD] = 1'b1;
        end
        if (op_go && (op_i == CTU_OP_ST_HANDLER || op_i == CTU_OP_ST_SAVED)) begin
            events[`CTU_BIT_STORE_GUARD] = 1'b1;
        end
        events = events & enables[pri_i][15:0];
        events[`CTU_BIT_SW_FORCED] = sw_forced_i;
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            CTU_ST_IDLE: begin
                next_cnt = 2'h0;
                if (take_trap) begin
                    next_state = CTU_ST_READ;
                end else if (op_go) begin
                    case (op_i)
                        CTU_OP_LD_HANDLER, CTU_OP_LD_SAVED: begin
                            if (!guard_load) begin
                                next_state = CTU_ST_READ;
                            end
                        end
                        CTU_OP_ST_HANDLER, CTU_OP_ST_SAVED: begin
                            if (!guard_store) begin
                                next_state = CTU_ST_READ;
                            end
                        end
                        CTU_OP_TRAP_RET: begin
                            next_state = CTU_ST_READ;
                        end
                        default: begin
                            next_state = CTU_ST_IDLE;
                        end
                    endcase
                end
            end
            CTU_ST_READ: begin
                if (mem_ack_i) begin
                    next_cnt = cnt + 2'h1;
                end
                if (last_ack) begin
                    if (job == CTU_JOB_RET) begin
                        next_state = CTU_ST_APPLY;
                    end else if (job == CTU_JOB_TRAP && buf_q[`CTU_OFF_WPTR] == `CTU_NULL_WPTR) begin
                        next_state = CTU_ST_IDLE;
                    end else begin
                        next_state = CTU_ST_WRITE;
                    end
                end
            end
            CTU_ST_WRITE: begin
                if (mem_ack_i) begin
                    next_cnt = cnt + 2'h1;
                end
                if (last_ack) begin
                    next_state = (job == CTU_JOB_TRAP) ? CTU_ST_APPLY : CTU_ST_IDLE;
                end
            end
            CTU_ST_APPLY: begin
                next_state = CTU_ST_IDLE;
            end
            default: begin
                next_state = CTU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= CTU_ST_IDLE;
            cnt <= 2'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // job setup
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            job <= CTU_JOB_COPY;
            src_base <= 32'h0;
            dst_base <= 32'h0;
            job_pri <= 1'b0;
            job_cause <= 4'h0;
            sv_iptr <= 32'h0;
            sv_wptr <= 32'h0;
        end else if (take_trap) begin
            job <= CTU_JOB_TRAP;
            job_pri <= pri_i;
            job_cause <= pend_idx;
            src_base <= slot(`CTU_HANDLER_BASE, pri_i, group_of(pend_idx));
            dst_base <= slot(`CTU_SAVED_BASE, pri_i, group_of(pend_idx));
            sv_iptr <= ctx_i.iptr;
            sv_wptr <= ctx_i.wptr;
        end else if (op_go) begin
            job_pri <= pri_i;
            job <= (op_i == CTU_OP_TRAP_RET) ? CTU_JOB_RET : CTU_JOB_COPY;
            case (op_i)
                CTU_OP_LD_HANDLER: begin
                    src_base <= stack_i.b;
                    dst_base <= slot(`CTU_HANDLER_BASE, stack_i.c[0], stack_i.a[1:0]);
                end
                CTU_OP_ST_HANDLER: begin
                    src_base <= slot(`CTU_HANDLER_BASE, stack_i.c[0], stack_i.a[1:0]);
                    dst_base <= stack_i.b;
                end
                CTU_OP_LD_SAVED: begin
                    src_base <= stack_i.b;
                    dst_base <= slot(`CTU_SAVED_BASE, pri_i, stack_i.a[1:0]);
                end
                CTU_OP_ST_SAVED: begin
                    src_base <= slot(`CTU_SAVED_BASE, pri_i, stack_i.a[1:0]);
                    dst_base <= stack_i.b;
                end
                CTU_OP_TRAP_RET: begin
                    src_base <= slot(`CTU_SAVED_BASE, pri_i, group_of(cause_taken[pri_i]));
                end
                default: begin
                    src_base <= src_base;
                end
            endcase
        end
    end

    // ****************************************
    // memory port
    // ****************************************
    // saved-process words, same layout as a handler descriptor
    always_comb begin
        wdata = buf_q[next_cnt];
        if (job == CTU_JOB_TRAP) begin
            case (next_cnt)
                `CTU_OFF_ENABLES: wdata = enables[job_pri];
                `CTU_OFF_STATUS: wdata = {16'h0, status[job_pri]};
                `CTU_OFF_WPTR: wdata = sv_wptr;
                default: wdata = sv_iptr;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_o <= '0;
        end else begin
            mem_o.req <= (next_state == CTU_ST_READ) || (next_state == CTU_ST_WRITE);
            mem_o.we <= (next_state == CTU_ST_WRITE);
            mem_o.addr <= ((next_state == CTU_ST_WRITE) ? dst_base : src_base) + {28'h0, next_cnt, 2'h0};
            mem_o.wdata <= wdata;
            if (state == CTU_ST_IDLE) begin
                // the bases only settle one edge after the op is taken
                mem_o.req <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int k = 0; k < 4; k++) begin
                buf_q[k] <= 32'h0;
            end
        end else if (state == CTU_ST_READ && mem_ack_i && mem_o.req) begin
            buf_q[cnt] <= mem_rdata_i;
        end
    end

    // ****************************************
    // enables and status
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            enables[0] <= `CTU_ENABLES_RST;
            enables[1] <= `CTU_ENABLES_RST;
            areg_o <= 32'h0;
        end else if (op_go && op_i == CTU_OP_MASK_SET) begin
            enables[stack_i.b[0]][15:0] <= enables[stack_i.b[0]][15:0] | stack_i.a[15:0];
            areg_o <= {16'h0, enables[stack_i.b[0]][15:0]};
        end else if (op_go && op_i == CTU_OP_MASK_CLR) begin
            enables[stack_i.b[0]][15:0] <= enables[stack_i.b[0]][15:0] & ~stack_i.a[15:0];
            areg_o <= {16'h0, enables[stack_i.b[0]][15:0]};
        end else if (state == CTU_ST_APPLY && job == CTU_JOB_TRAP) begin
            enables[job_pri] <= enables[job_pri] & buf_q[`CTU_OFF_ENABLES];
        end else if (state == CTU_ST_APPLY && job == CTU_JOB_RET) begin
            enables[job_pri] <= buf_q[`CTU_OFF_ENABLES];
        end
    end

    // a new event at the loaded priority wins over the load or clear in the same cycle; one at the other priority is lost
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            status[0] <= `CTU_STATUS_RST;
            status[1] <= `CTU_STATUS_RST;
            cause_taken[0] <= 4'h0;
            cause_taken[1] <= 4'h0;
        end else begin
            if (take_trap) begin
                cause_taken[pri_i] <= pend_idx;
            end
            if (state == CTU_ST_APPLY && job == CTU_JOB_TRAP) begin
                status[job_pri] <= buf_q[`CTU_OFF_STATUS][15:0] | (job_pri == pri_i ? events : 16'h0);
            end else if (state == CTU_ST_APPLY && job == CTU_JOB_RET) begin
                status[job_pri] <= (buf_q[`CTU_OFF_STATUS][15:0] & ~(16'h1 << cause_taken[job_pri]))
                    | (job_pri == pri_i ? events : 16'h0);
            end else begin
                status[pri_i] <= status[pri_i] | events;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            ctx_load_o <= 1'b0;
            ctx_o <= '0;
            trap_cause_o <= 4'h0;
        end else begin
            busy_o <= (next_state != CTU_ST_IDLE);
            done_o <= (op_go && next_state == CTU_ST_IDLE)
                || (state == CTU_ST_APPLY)
                || (state != CTU_ST_IDLE && next_state == CTU_ST_IDLE);
            ctx_load_o <= (state == CTU_ST_APPLY);
            if (state == CTU_ST_APPLY) begin
                ctx_o.iptr <= buf_q[`CTU_OFF_IPTR];
                ctx_o.wptr <= buf_q[`CTU_OFF_WPTR];
                ctx_o.status <= buf_q[`CTU_OFF_STATUS];
                trap_cause_o <= job_cause;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            enables_o <= 64'h0;
            status_o <= 32'h0;
        end else begin
            enables_o <= {enables[1], enables[0]};
            status_o <= {status[1], status[0]};
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence mask_op_s(ctu_op_e o);
        op_go && op_i == o;
    endsequence

    sequence trap_start_s;
        take_trap ##1 (state == CTU_ST_READ && job == CTU_JOB_TRAP);
    endsequence

    mask_set_a: assert property (mask_op_s(CTU_OP_MASK_SET) |=>
        (enables[$past(stack_i.b[0])][15:0] == ($past(enables[stack_i.b[0]][15:0]) | $past(stack_i.a[15:0]))))
        else $error("mask set result wrong");
    mask_clr_a: assert property (mask_op_s(CTU_OP_MASK_CLR) |=>
        (enables[$past(stack_i.b[0])][15:0] == ($past(enables[stack_i.b[0]][15:0]) & ~$past(stack_i.a[15:0]))))
        else $error("mask clear result wrong");
    old_mask_a: assert property ((mask_op_s(CTU_OP_MASK_SET) or mask_op_s(CTU_OP_MASK_CLR)) |=>
        (areg_o[15:0] == $past(enables[stack_i.b[0]][15:0])) && done_o)
        else $error("previous mask not returned");
    load_guard_a: assert property ((load_op && guard_load) |=>
        state == CTU_ST_IDLE ##1 (!mem_o.req && status[$past(pri_i, 2)][`CTU_BIT_LOAD_GUARD]))
        else $error("load guard did not block");
    store_guard_a: assert property ((store_op && guard_store) |=>
        (state == CTU_ST_IDLE && status[$past(pri_i)][`CTU_BIT_STORE_GUARD]))
        else $error("store guard did not block");
    trap_entry_a: assert property (trap_start_s |->
        ##[1:2] (mem_o.req && !mem_o.we && mem_o.addr[3:0] == 4'h0))
        else $error("trap entry did not read handler");
    null_handler_a: assert property ((ctx_load_o && job == CTU_JOB_TRAP) |->
        ctx_o.wptr != `CTU_NULL_WPTR)
        else $error("null handler entered");
    entry_and_a: assert property ((state == CTU_ST_APPLY && job == CTU_JOB_TRAP) |=>
        enables[$past(job_pri)] == ($past(enables[job_pri]) & $past(buf_q[`CTU_OFF_ENABLES])))
        else $error("entry mask not anded");
    bad_op_a: assert property ((op_go && op_i == CTU_OP_BAD_OP && enables[pri_i][`CTU_BIT_BAD_OP]) |=>
        status[$past(pri_i)][`CTU_BIT_BAD_OP])
        else $error("bad opcode not recorded");
endmodule

`default_nettype wire

// *** include/ctu_regs.svh ***
// constants for the trap handling unit: offsets, bit positions, bases
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH

// descriptor word offsets
`define CTU_OFF_ENABLES 2'h0
`define CTU_OFF_STATUS 2'h1
`define CTU_OFF_WPTR 2'h2
`define CTU_OFF_IPTR 2'h3
`define CTU_LAST_WORD 2'h3

// cause bit positions
`define CTU_BIT_BREAK 4'h0
`define CTU_BIT_BAD_OP 4'h3
`define CTU_BIT_LOAD_GUARD 4'h4
`define CTU_BIT_STORE_GUARD 4'h5
`define CTU_BIT_SW_FORCED 4'hf
`define CTU_CAUSE_W 14

// group codes
`define CTU_GRP_BREAK 2'h0
`define CTU_GRP_ERRORS 2'h1
`define CTU_GRP_SYSTEM 2'h2
`define CTU_GRP_SCHED 2'h3

// memory placement of the handler and saved-process tables
`define CTU_HANDLER_BASE 32'h0000_0100
`define CTU_SAVED_BASE 32'h0000_0200
`define CTU_NULL_WPTR 32'h0000_0000

// reset values
`define CTU_ENABLES_RST 32'h0000_0000
`define CTU_STATUS_RST 16'h0000

`endif

// *** include/ctu_pkg.sv ***
// types shared by the trap handling unit and its surroundings
package ctu_pkg;

    typedef enum logic [2:0] {
        CTU_OP_LD_HANDLER = 3'h0,
        CTU_OP_ST_HANDLER = 3'h1,
        CTU_OP_LD_SAVED = 3'h2,
        CTU_OP_ST_SAVED = 3'h3,
        CTU_OP_MASK_SET = 3'h4,
        CTU_OP_MASK_CLR = 3'h5,
        CTU_OP_TRAP_RET = 3'h6,
        CTU_OP_BAD_OP = 3'h7
    } ctu_op_e;

    typedef enum logic [3:0] {
        CTU_ST_IDLE = 4'h1,
        CTU_ST_READ = 4'h2,
        CTU_ST_WRITE = 4'h4,
        CTU_ST_APPLY = 4'h8
    } ctu_state_e;

    typedef enum logic [1:0] {
        CTU_JOB_COPY = 2'h0,
        CTU_JOB_TRAP = 2'h1,
        CTU_JOB_RET = 2'h2
    } ctu_job_e;

    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
    } ctu_stack_s;

    typedef struct packed {
        logic [31:0] iptr;
        logic [31:0] wptr;
        logic [31:0] status;
    } ctu_ctx_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ctu_mem_s;

endpackage

// *** logic/ctu_lowest_bit.sv ***
// lowest set bit finder for pending trap causes
`timescale 1ns/1ps
`default_nettype none

module ctu_lowest_bit (
    input wire logic [13:0] vec_i,
    output logic any_o,
    output logic [3:0] idx_o
);
    logic [14:0] seen;
    logic [13:0] hit;

    assign seen[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < 14; i++) begin : g_bit
            assign hit[i] = vec_i[i] & ~seen[i];
            assign seen[i + 1] = seen[i] | vec_i[i];
        end
    endgenerate

    assign any_o = seen[14];

    always_comb begin
        idx_o = 4'h0;
        for (int k = 0; k < 14; k++) begin
            if (hit[k]) begin
                idx_o = 4'(k);
            end
        end
    end
endmodule

`default_nettype wire

// *** bench/ctu_mem_model.sv ***
// memory partner model answering the trap unit's word requests
`timescale 1ns/1ps
`default_nettype none
module ctu_mem_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire ctu_pkg::ctu_mem_s mem_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    import ctu_pkg::*;
    // ****************
    // word store
    // ****************
    logic [31:0] mem [0:1023];
    logic [2:0] wait_cnt;
    // idle read data toggles so a stale word never looks valid
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 3'h0;
            rdata_o <= 32'h0;
        end else if (ack_o || !mem_i.req) begin
            ack_o <= 1'b0;
            wait_cnt <= 3'h0;
            rdata_o <= ~rdata_o;
        end else if (wait_cnt < (slow_i ? 3'h3 : 3'h0)) begin
            wait_cnt <= wait_cnt + 3'h1;
            rdata_o <= ~rdata_o;
        end else begin
            ack_o <= 1'b1;
            rdata_o <= mem[mem_i.addr[11:2]];
            if (mem_i.we) begin
                mem[mem_i.addr[11:2]] <= mem_i.wdata;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_cpu_trap_handling_unit.sv ***
// testbench for the trap handling unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_trap_handling_unit;
    import ctu_pkg::*;
    logic clk_i, reset_i, op_valid_i, pri_i, interruptible_i, sw_forced_i, mem_ack_i, slow, loaded, busied;
    logic busy_o, done_o, ctx_load_o;
    ctu_op_e op_i;
    ctu_stack_s stack_i;
    ctu_ctx_s ctx_i, ctx_o;
    ctu_mem_s mem_o;
    logic [13:0] cond_i;
    logic [31:0] mem_rdata_i, areg_o, status_o;
    logic [3:0] trap_cause_o;
    logic [63:0] enables_o;
    int error_cnt, num_checks, cycles;
    ctu_trap_unit ctu_trap_unit_inst (.clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .stack_i(stack_i), .pri_i(pri_i), .ctx_i(ctx_i), .interruptible_i(interruptible_i), .cond_i(cond_i),
        .sw_forced_i(sw_forced_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
        .busy_o(busy_o), .done_o(done_o), .areg_o(areg_o), .ctx_load_o(ctx_load_o), .ctx_o(ctx_o),
        .trap_cause_o(trap_cause_o), .enables_o(enables_o), .status_o(status_o));
    ctu_mem_model ctu_mem_model_inst (.clk_i(clk_i), .reset_i(reset_i), .mem_i(mem_o), .slow_i(slow),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    // ****************
    // tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // bounded wait; extra cycle lets the delayed status and enables copies land
    task automatic wait_done();
        loaded = 1'b0;
        busied = busy_o;
        for (int n = 0; n < 300 && done_o !== 1'b1; n++) begin
            @(negedge clk_i);
            loaded = loaded | ctx_load_o;
            busied = busied | busy_o;
        end
        @(negedge clk_i);
    endtask
    task automatic op(input ctu_op_e o, input logic [31:0] a, input logic [31:0] b);
        op_i = o;
        stack_i = '{a, b, 32'h0};
        op_valid_i = 1'b1;
        @(negedge clk_i);
        op_valid_i = 1'b0;
        wait_done();
    endtask
    // cause held one edge, interruptible two, so the recorded status meets an interruptible edge
    task automatic raise(input logic [13:0] c);
        interruptible_i = 1'b1;
        cond_i = c;
        @(negedge clk_i);
        cond_i = 14'h0;
        @(negedge clk_i);
        interruptible_i = 1'b0;
        wait_done();
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ****************
    // tests
    // ****************
    initial begin
        {reset_i, op_valid_i, pri_i, interruptible_i, sw_forced_i, slow} = 6'b100000;
        op_i = CTU_OP_MASK_SET;
        stack_i = '0;
        ctx_i = '{32'h55, 32'h77, 32'h0};
        cond_i = 14'h0;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        @(negedge clk_i);
        chk("enables", enables_o[31:0], 32'h0);
        op(CTU_OP_MASK_SET, 32'h38, 32'h0);
        chk("areg", areg_o, 32'h0);
        chk("enables", enables_o[31:0], 32'h38);
        chk("busy", {31'h0, busied}, 32'h0);
        op(CTU_OP_LD_HANDLER, 32'h0, 32'h40);
        chk("status", status_o, 32'h10);
        op(CTU_OP_ST_SAVED, 32'h0, 32'h40);
        chk("status", status_o, 32'h30);
        op(CTU_OP_BAD_OP, 32'h0, 32'h0);
        chk("status", status_o, 32'h38);
        cond_i = 14'h80;
        wait_done();
        chk("status", status_o, 32'h38);
        op(CTU_OP_MASK_CLR, 32'h38, 32'h0);
        chk("areg", areg_o, 32'h38);
        chk("enables", enables_o[31:0], 32'h0);
        $display("test mask and guards done");
        // handler mask clears its own group's enable
        ctu_mem_model_inst.mem[16] = 32'hfffe;
        ctu_mem_model_inst.mem[17] = 32'h0;
        ctu_mem_model_inst.mem[18] = 32'h1000;
        ctu_mem_model_inst.mem[19] = 32'h2000;
        slow = 1'b1;
        op(CTU_OP_LD_HANDLER, 32'h0, 32'h40);
        op(CTU_OP_ST_HANDLER, 32'h0, 32'h80);
        slow = 1'b0;
        chk("busy", {31'h0, busied}, 32'h1);
        chk("busy", {31'h0, busy_o}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            chk("slot", ctu_mem_model_inst.mem[64 + k], ctu_mem_model_inst.mem[16 + k]);
            chk("copy", ctu_mem_model_inst.mem[32 + k], ctu_mem_model_inst.mem[16 + k]);
        end
        $display("test transfers done");
        op(CTU_OP_MASK_SET, 32'h1, 32'h0);
        raise(14'h1);
        chk("load", {31'h0, loaded}, 32'h1);
        chk("iptr", ctx_o.iptr, 32'h2000);
        chk("wptr", ctx_o.wptr, 32'h1000);
        chk("cause", {28'h0, trap_cause_o}, 32'h0);
        chk("enables", enables_o[31:0], 32'h0);
        chk("status", status_o, 32'h0);
        chk("sv mask", ctu_mem_model_inst.mem[128], 32'h1);
        chk("sv status", ctu_mem_model_inst.mem[129], 32'h39);
        chk("sv wptr", ctu_mem_model_inst.mem[130], 32'h77);
        chk("sv iptr", ctu_mem_model_inst.mem[131], 32'h55);
        // handler leaves by trap return only
        op(CTU_OP_TRAP_RET, 32'h0, 32'h0);
        chk("load", {31'h0, loaded}, 32'h1);
        chk("iptr", ctx_o.iptr, 32'h55);
        chk("sv status", ctx_o.status, 32'h39);
        chk("status", status_o, 32'h38);
        chk("enables", enables_o[31:0], 32'h1);
        $display("test trap entry and return done");
        ctu_mem_model_inst.mem[78] = 32'h0;
        op(CTU_OP_MASK_SET, 32'h40, 32'h0);
        raise(14'h40);
        chk("load", {31'h0, loaded}, 32'h0);
        chk("status", status_o, 32'h78);
        $display("test null handler done");
        op(CTU_OP_MASK_SET, 32'h2, 32'h1);
        chk("areg", areg_o, 32'h0);
        chk("enables", enables_o[63:32], 32'h2);
        op(CTU_OP_LD_SAVED, 32'h0, 32'h40);
        chk("saved", ctu_mem_model_inst.mem[128], 32'hfffe);
        sw_forced_i = 1'b1;
        @(negedge clk_i);
        sw_forced_i = 1'b0;
        @(negedge clk_i);
        chk("status", status_o, 32'h8078);
        $display("test priority and forced done");
        conclude();
    end
endmodule
`default_nettype wire
